/* File: design/gsel_pkg.sv */
package gsel_pkg;

    // Group count and widths
    localparam int GSEL_GROUPS = 8;
    localparam int GSEL_IDXW   = 3;
    localparam int GSEL_STAMPW = 32;

    // Event status vector layout
    localparam int GSEL_EV_ENABLED   = 0;
    localparam int GSEL_EV_REQUEST   = 8;
    localparam int GSEL_EV_ACTIVE    = 16;
    localparam int GSEL_EV_REMOTE    = 24;
    localparam int GSEL_EV_LOCAL     = 25;
    localparam int GSEL_EV_FORCE     = 26;
    localparam int GSEL_EV_FAIL_CFG  = 27;
    localparam int GSEL_EV_FAIL_FRC  = 28;
    localparam int GSEL_EV_FAIL_PRIO = 29;
    localparam int GSEL_EVW          = 30;
    localparam int GSEL_EVIDW        = 5;

    // Reset and fixed values
    localparam logic [7:0]            GSEL_ONE_HOT1  = 8'h01;
    localparam logic [7:0]            GSEL_NONE      = 8'h00;
    localparam logic [7:0]            GSEL_ACT_RST   = 8'h01;
    localparam logic [7:0]            GSEL_USED_MIN  = 8'h01;
    localparam logic [GSEL_EVW-1:0]   GSEL_EV_ZERO   = 30'h0;
    localparam logic [GSEL_EVIDW-1:0] GSEL_EVID_ZERO = 5'h00;
    localparam logic [31:0]           GSEL_STAMP_RST = 32'h0;

    typedef logic [GSEL_GROUPS-1:0] gsel_group_t;

endpackage : gsel_pkg

/* File: design/gsel_event_queue.sv */
`timescale 1ns/1ps
module gsel_event_queue
    import gsel_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // Status and selection
    input  wire logic [GSEL_EVW-1:0]     statusVec,
    input  wire logic [GSEL_EVW-1:0]     onEnable,
    input  wire logic [GSEL_EVW-1:0]     offEnable,
    input  wire logic [GSEL_STAMPW-1:0]  timeStamp,
    // Event out
    output logic                         eventValid,
    output logic [GSEL_EVIDW-1:0]        eventId,
    output logic                         eventOn,
    output logic [GSEL_STAMPW-1:0]       eventStamp
);

    logic [GSEL_EVW-1:0]    prev_q;
    logic [GSEL_EVW-1:0]    pend_q;
    logic [GSEL_EVW-1:0]    pend_d;
    logic [GSEL_EVW-1:0]    lvl_q;
    logic [GSEL_EVW-1:0]    keep;
    logic [GSEL_EVW-1:0]    grant;
    logic [GSEL_STAMPW-1:0] stamp_q [GSEL_EVW];
    logic                   valid_d;
    logic [GSEL_EVIDW-1:0]  id_d;
    logic                   on_d;
    logic [GSEL_STAMPW-1:0] stampSel;

    // [R9] On/off filter
    assign keep   = (statusVec ^ prev_q) & ((statusVec & onEnable) | (~statusVec & offEnable));
    assign grant  = pend_q & (~pend_q + GSEL_EV_ZERO + 30'h1);
    // New change on a granted bit re-arms it, so set wins
    assign pend_d = keep | (pend_q & ~grant);

    genvar gi;
    generate
        for (gi = 0; gi < GSEL_EVW; gi++) begin : g_entry
            // [R10] Stamp at change
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    stamp_q[gi] <= GSEL_STAMP_RST;
                    lvl_q[gi]   <= 1'b0;
                end else if (keep[gi]) begin
                    stamp_q[gi] <= timeStamp;
                    lvl_q[gi]   <= statusVec[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        valid_d  = |grant;
        id_d     = GSEL_EVID_ZERO;
        on_d     = 1'b0;
        stampSel = GSEL_STAMP_RST;
        for (int i = 0; i < GSEL_EVW; i++) begin
            if (grant[i]) begin
                id_d     = GSEL_EVIDW'(i);
                on_d     = lvl_q[i];
                stampSel = stamp_q[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q     <= GSEL_EV_ZERO;
            pend_q     <= GSEL_EV_ZERO;
            eventValid <= 1'b0;
            eventId    <= GSEL_EVID_ZERO;
            eventOn    <= 1'b0;
            eventStamp <= GSEL_STAMP_RST;
        end else begin
            prev_q     <= statusVec;
            pend_q     <= pend_d;
            eventValid <= valid_d;
            eventId    <= id_d;
            eventOn    <= on_d;
            eventStamp <= stampSel;
        end
    end

endmodule : gsel_event_queue

/* File: design/gsel_selector.sv */
`timescale 1ns/1ps
// Behaviour
// [R1] Eight request inputs, input 1 highest priority, ties go to higher.
// [R2] Each request input works as a pulse or as a held level.
// [R3] Held request on group 1 blocks every other request.
// [R4] Held request on groups 2 to 7 blocks only lower-priority requests.
// [R5] Held request on group 7 blocks only group 8.
// [R6] Held request on group 8 blocks nothing.
// [R7] No automatic return to group 1; only a new request selects it.
// [R8] Outside logic drives group 1 from coil status, group 2 inverse.
// [R9] Each status change is an event; per-event on/off storage selection.
// [R10] Each event carries the time stamp of its status change.
// [R11] Request to an unconfigured group flags failure with on/off events.
// [R12] Requests lost to priority or to override flag failures.
// [R13] Remote and local change requests give separate on/off events.
// [R14] Pulse-selected group stays active until another group is requested.
// [R15] Override enable suspends input selection; commanded group applies.
// [R16] After reset only group 1 is enabled and active.
// [R17] Active group as one-hot output, updated edge after winning request.
module gsel_selector
    import gsel_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // Group request inputs, bit 0 is group 1
    input  wire logic [7:0]             groupReq,
    // Configuration
    input  wire logic [7:0]             usedGroups,
    input  wire logic [GSEL_EVW-1:0]    eventOnEnable,
    input  wire logic [GSEL_EVW-1:0]    eventOffEnable,
    // Remote and local change requests
    input  wire logic                   remoteReq,
    input  wire logic [GSEL_IDXW-1:0]   remoteGroup,
    input  wire logic                   localReq,
    input  wire logic [GSEL_IDXW-1:0]   localGroup,
    // Override
    input  wire logic                   group_override_enable,
    input  wire logic                   overrideValid,
    input  wire logic [GSEL_IDXW-1:0]   overrideGroup,
    // Time base
    input  wire logic [GSEL_STAMPW-1:0] timeStamp,
    // Status
    output logic [7:0]                  activeGroup,
    output logic [7:0]                  enabledGroups,
    output logic                        failNotConfigured,
    output logic                        failLowerPriority,
    output logic                        failOverride,
    // Events from gsel_event_queue
    output logic                        eventValid,
    output logic [GSEL_EVIDW-1:0]       eventId,
    output logic                        eventOn,
    output logic [GSEL_STAMPW-1:0]      eventStamp
);

    gsel_group_t reqPrev_q;
    gsel_group_t active_q;
    gsel_group_t active_d;
    gsel_group_t used_q;
    gsel_group_t used_d;
    gsel_group_t reqRise;
    gsel_group_t remoteHot;
    gsel_group_t localHot;
    gsel_group_t allReq;
    gsel_group_t blocked;
    gsel_group_t cand;
    gsel_group_t winner;
    gsel_group_t ovrHot;
    logic        failCfg_q;
    logic        failCfg_d;
    logic        failPrio_q;
    logic        failPrio_d;
    logic        failFrc_q;
    logic        failFrc_d;
    logic        remote_q;
    logic        local_q;
    logic        force_q;
    logic        ovrApply;
    logic        accept;
    logic [GSEL_EVW-1:0] statusVec;

    // [R2] Edge is the request, level is the hold
    assign reqRise   = groupReq & ~reqPrev_q;
    assign remoteHot = remoteReq ? (GSEL_ONE_HOT1 << remoteGroup) : GSEL_NONE;
    assign localHot  = localReq ? (GSEL_ONE_HOT1 << localGroup) : GSEL_NONE;
    assign ovrHot    = GSEL_ONE_HOT1 << overrideGroup;
    assign allReq    = reqRise | remoteHot | localHot;

    // [R3] Held levels block lower groups
    assign blocked[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 1; gi < GSEL_GROUPS; gi++) begin : g_block
            // [R4] Cumulative block chain
            assign blocked[gi] = blocked[gi-1] | groupReq[gi-1];
        end
    endgenerate
    // [R5] [R6] Group 8 level never enters the chain

    // [R1] Lowest index wins
    assign cand   = allReq & ~blocked & used_q;
    assign winner = cand & (~cand + GSEL_ONE_HOT1);

    // [R15] Override takes the selection
    assign ovrApply = group_override_enable & overrideValid & |(ovrHot & used_q);
    assign accept   = group_override_enable ? ovrApply : (winner != GSEL_NONE);

    always_comb begin
        // [R16] Group 1 always stays enabled
        used_d   = usedGroups | GSEL_USED_MIN;
        active_d = active_q;
        if (group_override_enable) begin
            if (ovrApply) begin
                active_d = ovrHot;
            end
        end else if (winner != GSEL_NONE) begin
            // [R14] Pulse selection latches
            active_d = winner;
        end
        // [R7] Otherwise hold, no fallback
    end

    always_comb begin
        // [R11] Unconfigured target
        failCfg_d  = (group_override_enable ?
                      (overrideValid & ~|(ovrHot & used_q)) :
                      |(allReq & ~used_q)) | (failCfg_q & ~accept);
        // [R12] Priority loss and override refusal
        failPrio_d = (~group_override_enable & |(allReq & used_q & ~winner))
                   | (failPrio_q & ~accept);
        failFrc_d  = (group_override_enable & |allReq)
                   | (failFrc_q & ~(accept & ~|allReq));
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reqPrev_q  <= GSEL_NONE;
            active_q   <= GSEL_ACT_RST;
            used_q     <= GSEL_USED_MIN;
            failCfg_q  <= 1'b0;
            failPrio_q <= 1'b0;
            failFrc_q  <= 1'b0;
            remote_q   <= 1'b0;
            local_q    <= 1'b0;
            force_q    <= 1'b0;
        end else begin
            reqPrev_q  <= groupReq;
            active_q   <= active_d;
            used_q     <= used_d;
            failCfg_q  <= failCfg_d;
            failPrio_q <= failPrio_d;
            failFrc_q  <= failFrc_d;
            // [R13] Change request status
            remote_q   <= remoteReq;
            local_q    <= localReq;
            force_q    <= group_override_enable;
        end
    end

    // [R17] Outputs straight from flops
    assign activeGroup       = active_q;
    assign enabledGroups     = used_q;
    assign failNotConfigured = failCfg_q;
    assign failLowerPriority = failPrio_q;
    assign failOverride      = failFrc_q;

    // [R9] Status vector for events
    assign statusVec = {failPrio_q, failFrc_q, failCfg_q, force_q, local_q, remote_q,
                        active_q, reqPrev_q, used_q};

    // [R10] Stamped event stream
    gsel_event_queue u_events (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .statusVec  (statusVec),
        .onEnable   (eventOnEnable),
        .offEnable  (eventOffEnable),
        .timeStamp  (timeStamp),
        .eventValid (eventValid),
        .eventId    (eventId),
        .eventOn    (eventOn),
        .eventStamp (eventStamp)
    );

    // Assertions
    // [R17] One-hot active
    one_hot_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R17]
        $onehot(active_q))
        else $error("active group not one-hot");

    // [R3] Held group 1
    group1_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
        (groupReq[0] && reqPrev_q[0] && active_q[0] && !group_override_enable)
        |=> active_q[0])
        else $error("held group 1 lost");

    // [R3] Group 1 blocks all
    g1_block_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
        (!group_override_enable && groupReq[0]) |=> ($stable(active_q) || active_q[0]))
        else $error("held group 1 let another group in");

    // [R1] Tie to higher
    prio_win_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
        (!group_override_enable && reqRise[0] && reqRise[1] && used_q[0])
        |=> active_q[0])
        else $error("higher group lost tie");

    // [R2] Pulse selects group
    pulse_pick_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
        (!group_override_enable && reqRise[4] && used_q[4] && !(|groupReq[3:0])
         && !(|remoteHot[3:0]) && !(|localHot[3:0])) |=> active_q[4])
        else $error("pulse request not taken");

    // [R4] Held block below
    block_low_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
        (!group_override_enable && groupReq[1] && !active_q[7] && !remoteReq && !localReq)
        |=> !active_q[7])
        else $error("lower group passed a held block");

    // [R5] Group 7 blocks 8
    g7_block_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
        (!group_override_enable && groupReq[6] && !active_q[7]) |=> !active_q[7])
        else $error("group 8 passed held group 7");

    // [R5] Group 7 passes higher
    g7_pass_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
        (!group_override_enable && groupReq[6] && reqRise[5] && used_q[5]
         && !(|groupReq[4:0]) && !(|remoteHot[4:0]) && !(|localHot[4:0]))
        |=> active_q[5])
        else $error("held group 7 blocked group 6");

    // [R6] Group 8 blocks nothing
    g8_noblock_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
        (!group_override_enable && reqRise[6] && used_q[6] && groupReq[7]
         && !(|groupReq[5:0]) && !(|remoteHot[5:0]) && !(|localHot[5:0]))
        |=> active_q[6])
        else $error("group 8 level blocked group 7");

    // [R7] No return to 1
    no_revert_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R7]
        (!group_override_enable && !active_q[0] && !allReq[0]) |=> !active_q[0])
        else $error("group 1 selected without request");

    // [R14] Pulse selection latches
    latch_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R14]
        (!group_override_enable && allReq == GSEL_NONE) |=> $stable(active_q))
        else $error("active group changed without request");

    // [R11] Unconfigured request flagged
    cfg_fail_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
        (!group_override_enable && |(allReq & ~used_q)) |=> failCfg_q)
        else $error("unconfigured request not flagged");

    // [R11] Unconfigured override flagged
    ovr_cfg_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
        (group_override_enable && overrideValid && !(|(ovrHot & used_q))) |=> failCfg_q)
        else $error("unconfigured override not flagged");

    // [R12] Priority loss flagged
    prio_fail_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R12]
        (!group_override_enable && reqRise[1] && used_q[1] && groupReq[0]) |=> failPrio_q)
        else $error("blocked request not flagged");

    // [R12] Override refusal flagged
    force_fail_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R12]
        (group_override_enable && allReq != GSEL_NONE) |=> failFrc_q)
        else $error("request under override not flagged");

    // [R15] Override applies target
    ovr_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R15]
        ovrApply |=> (active_q == $past(ovrHot)) && (failFrc_q || ($past(allReq) == GSEL_NONE)))
        else $error("override not applied");

    // [R15] Inputs ignored under override
    ovr_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R15]
        (group_override_enable && !ovrApply) |=> $stable(active_q))
        else $error("active group moved under override");

    // [R16] Enabled set tracks
    used_track_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R16]
        1'b1 |=> (used_q == ($past(usedGroups) | GSEL_USED_MIN)))
        else $error("enabled groups wrong");

    // [R9] Remote change event
    ev_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R9]
        $rose(remote_q) && eventOnEnable[GSEL_EV_REMOTE] |-> ##[1:40] eventValid)
        else $error("remote event not emitted");

    // [R13] Local change event
    local_ev_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
        $rose(local_q) && eventOnEnable[GSEL_EV_LOCAL] |-> ##[1:40] eventValid)
        else $error("local event not emitted");

    // Main scenarios
    pulse_cov: cover property (@(posedge mclk) disable iff (!reset_n)
        reqRise[3] && used_q[3] ##1 active_q[3] ##3 active_q[3]);
    override_cov: cover property (@(posedge mclk) disable iff (!reset_n)
        ovrApply ##1 failFrc_q);
    prio_cov: cover property (@(posedge mclk) disable iff (!reset_n)
        failPrio_q ##[1:20] eventValid);
    hold_cov: cover property (@(posedge mclk) disable iff (!reset_n)
        groupReq[6] && reqRise[7]);
    local_cov: cover property (@(posedge mclk) disable iff (!reset_n)
        eventValid && eventOn && eventId == GSEL_EVIDW'(GSEL_EV_LOCAL));

endmodule : gsel_selector

/* File: bench/gsel_app_model.sv */
`timescale 1ns/1ps
module gsel_app_model (
    // Coil status and wire health
    input  wire logic       coil,
    input  wire logic       wireOk,
    input  wire logic       enable,
    // Requests for groups 1 and 2
    output logic [1:0]      groupOut
);
    // Inverse drives group 2
    // A broken wire reads as an open coil, so group 2 is requested
    assign groupOut = enable ? {~(coil & wireOk), coil & wireOk} : 2'h0;
endmodule : gsel_app_model

/* File: bench/gsel_selector_tb.sv */
`timescale 1ns/1ps
module gsel_selector_tb
    import gsel_pkg::*;
;
    logic              mclk = 1'b0, reset_n = 1'b0;
    logic [7:0]        reqDrv = 8'h00, usedGroups = 8'h01;
    wire  [7:0]        groupReq;
    wire  [1:0]        appReq;
    logic              coil = 1'b0, wireOk = 1'b1, appEn = 1'b0;
    logic [GSEL_EVW-1:0] onEn = GSEL_EV_ZERO, offEn = GSEL_EV_ZERO;
    logic              remoteReq = 1'b0, localReq = 1'b0, ovEn = 1'b0, ovValid = 1'b0;
    logic [2:0]        remoteGroup = 3'h0, localGroup = 3'h0, ovGroup = 3'h0;
    logic [31:0]       timeStamp = 32'h0, t0, rng = 32'hA08B;
    logic [7:0]        activeGroup, enabledGroups, mAct, mPrev, mUsed;
    logic              failNotConfigured, failLowerPriority, failOverride;
    logic              eventValid, eventOn, mCfg, mPrio, mFrc;
    logic [4:0]        eventId;
    logic [31:0]       eventStamp;
    logic [37:0]       evQ[$], expQ[$];
    int                mismatches = 0, n_compared = 0;

    initial forever #2.5 mclk = ~mclk;
    assign groupReq = reqDrv | {6'h00, appReq};

    gsel_app_model gsel_app_model_i (.coil(coil), .wireOk(wireOk), .enable(appEn),
        .groupOut(appReq));
    gsel_selector gsel_selector_i (.mclk(mclk), .reset_n(reset_n), .groupReq(groupReq),
        .usedGroups(usedGroups), .eventOnEnable(onEn), .eventOffEnable(offEn),
        .remoteReq(remoteReq), .remoteGroup(remoteGroup), .localReq(localReq),
        .localGroup(localGroup), .group_override_enable(ovEn), .overrideValid(ovValid),
        .overrideGroup(ovGroup), .timeStamp(timeStamp), .activeGroup(activeGroup),
        .enabledGroups(enabledGroups), .failNotConfigured(failNotConfigured),
        .failLowerPriority(failLowerPriority), .failOverride(failOverride),
        .eventValid(eventValid), .eventId(eventId), .eventOn(eventOn),
        .eventStamp(eventStamp));

    always @(posedge mclk) begin
        if (eventValid === 1'b1) begin
            evQ.push_back({eventId, eventOn, eventStamp});
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    task automatic checkGroup(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : checkGroup

    task automatic checkEvent(input logic [37:0] got, input logic [37:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t event got %h exp %h", $time, got, exp);
        end
    endtask : checkEvent

    // Reference selector, evaluated on the same edge as the design
    task automatic modelEdge();
        logic [7:0] used, req;
        logic       acc, fc, fp, ff;
        int         w;
        used = mUsed;
        req = (groupReq & ~mPrev) | ({7'h00, remoteReq} << remoteGroup)
            | ({7'h00, localReq} << localGroup);
        {acc, fc, fp, ff} = 4'h0;
        w = 8;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) w = i;
        end
        if (ovEn) begin
            ff = (req != 8'h00);
            if (ovValid && used[ovGroup]) begin
                acc = 1'b1;
                mAct = 8'h01 << ovGroup;
            end else if (ovValid) fc = 1'b1;
        end else if (w < 8) begin
            if ((groupReq & ((8'h01 << w) - 8'h01)) != 8'h00) fp = 1'b1;
            else if (!used[w]) fc = 1'b1;
            else begin
                acc = 1'b1;
                mAct = 8'h01 << w;
            end
            if ((req & ~(8'h01 << w)) != 8'h00) fp = 1'b1;
        end
        mPrev = groupReq;
        // Configured set is registered, so it takes effect one edge later
        mUsed = usedGroups | 8'h01;
        mCfg = fc | (mCfg & ~acc);
        mPrio = fp | (mPrio & ~acc);
        mFrc = ff | (mFrc & ~acc);
    endtask : modelEdge

    task automatic step(input int n);
        repeat (n) begin
            @(posedge mclk);
            modelEdge();
            #1;
            checkGroup(activeGroup, mAct, "active");
            checkGroup(enabledGroups, mUsed, "enabled");
            checkGroup({5'h00, failNotConfigured, failLowerPriority, failOverride},
                {5'h00, mCfg, mPrio, mFrc}, "fail flags");
            timeStamp = timeStamp + 32'h1;
        end
    endtask : step

    task automatic pulse(input logic [7:0] m);
        reqDrv = reqDrv | m;
        step(1);
        reqDrv = reqDrv & ~m;
        step(1);
    endtask : pulse

    initial begin
        #200us;
        mismatches++;
        summarize();
    end

    initial begin
        mAct = 8'h01;
        mPrev = 8'h00;
        mUsed = 8'h01;
        {mCfg, mPrio, mFrc} = 3'h0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        step(1);
        pulse(8'h04);
        usedGroups = 8'hFF;
        pulse(8'h04);
        step(5);
        pulse(8'h07);
        // Hold each group in turn and pulse every other one
        for (int h = 0; h < 8; h++) begin
            reqDrv = 8'h01 << h;
            step(1);
            for (int k = 7; k >= 0; k--) begin
                if (k != h) pulse(8'h01 << k);
            end
            reqDrv = 8'h00;
            step(1);
        end
        {ovEn, ovValid, ovGroup} = 5'h1C;
        step(2);
        pulse(8'h01);
        usedGroups = 8'h0F;
        ovGroup = 3'h6;
        step(2);
        usedGroups = 8'hFF;
        {ovEn, ovValid} = 2'h0;
        step(4);
        appEn = 1'b1;
        coil = 1'b1;
        step(2);
        coil = 1'b0;
        step(2);
        coil = 1'b1;
        step(2);
        wireOk = 1'b0;
        step(2);
        appEn = 1'b0;
        step(1);
        // Only remote on/off and local on are stored
        onEn[GSEL_EV_REMOTE] = 1'b1;
        onEn[GSEL_EV_LOCAL] = 1'b1;
        offEn[GSEL_EV_REMOTE] = 1'b1;
        step(40);
        evQ.delete();
        t0 = timeStamp;
        {remoteReq, remoteGroup} = 4'hA;
        step(1);
        remoteReq = 1'b0;
        step(4);
        {localReq, localGroup} = 4'hD;
        step(1);
        localReq = 1'b0;
        expQ.push_back({5'(GSEL_EV_REMOTE), 1'b1, t0 + 32'h1});
        expQ.push_back({5'(GSEL_EV_REMOTE), 1'b0, t0 + 32'h2});
        expQ.push_back({5'(GSEL_EV_LOCAL), 1'b1, t0 + 32'h6});
        for (int i = 0; i < 60 && evQ.size() < 3; i++) step(1);
        step(10);
        checkGroup(8'(evQ.size()), 8'h03, "event count");
        foreach (expQ[i]) begin
            if (i < evQ.size()) checkEvent(evQ[i], expQ[i]);
        end
        onEn = ~GSEL_EV_ZERO;
        offEn = ~GSEL_EV_ZERO;
        repeat (400) begin
            rng = xs(rng);
            reqDrv = rng[7:0] & rng[15:8] & rng[23:16];
            {remoteReq, remoteGroup} = {&rng[26:24], rng[29:27]};
            {localReq, localGroup} = {&rng[31:29], rng[2:0]};
            step(1);
        end
        {reqDrv, remoteReq, localReq} = 10'h000;
        step(2);
        summarize();
    end
endmodule : gsel_selector_tb
